// ===== logic/aif_pkg.sv
`default_nettype none
package aif_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets on the bus
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_ERRFEAT = 8'h04;
	localparam logic [7:0] OFS_SECCNT = 8'h08;
	localparam logic [7:0] OFS_SECNUM = 8'h0C;
	localparam logic [7:0] OFS_CYLLO = 8'h10;
	localparam logic [7:0] OFS_CYLHI = 8'h14;
	localparam logic [7:0] OFS_DRVHD = 8'h18;
	localparam logic [7:0] OFS_STATCMD = 8'h1C;
	localparam logic [7:0] OFS_CONFIG = 8'h20;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_DREQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_ABORT = 2;
	localparam int DRV_SEL = 4;
	localparam int CFG_GEOM = 0;
	localparam int CFG_MULT_LSB = 8;
	localparam int CFG_MULT_VALID = 16;
	localparam int CFG_RCACHE = 24;
	localparam int CFG_WCACHE = 25;

	////////////////////////////////////////////////////////////////////////////
	// reset values; cache bits come back to their saved state
	localparam logic CFG_GEOM_RST = 1'b0;
	localparam logic [7:0] CFG_MULT_RST = 8'h08;
	localparam logic CFG_MULT_VALID_RST = 1'b0;
	localparam logic RCACHE_SAVED = 1'b1;
	localparam logic WCACHE_SAVED = 1'b1;
	localparam logic [7:0] TASK_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// commands, key bytes and feature codes
	localparam logic [7:0] CMD_EXTENDED = 8'hF0;
	localparam logic [7:0] SUB_DEFECT = 8'h04;
	localparam logic [7:0] KEY_1 = 8'hFF;
	localparam logic [7:0] KEY_2 = 8'hFF;
	localparam logic [7:0] KEY_3 = 8'h3F;
	localparam logic [7:0] FEAT_RC_ON = 8'hAA;
	localparam logic [7:0] FEAT_RC_OFF = 8'h55;
	localparam logic [7:0] FEAT_WC_ON = 8'h02;
	localparam logic [7:0] FEAT_WC_OFF = 8'h82;

	////////////////////////////////////////////////////////////////////////////
	// parameter block contents
	localparam logic [15:0] ID_GENCFG = 16'h0A5A;
	localparam logic [15:0] CYL_A = 16'h03B0;
	localparam logic [15:0] CYL_B = 16'h0419;
	localparam logic [15:0] HEADS_A = 16'h000E;
	localparam logic [15:0] HEADS_B = 16'h0010;
	localparam logic [15:0] SPT_A = 16'h0028;
	localparam logic [15:0] SPT_B = 16'h003F;
	localparam logic [31:0] CAP_A = 32'h0008_1100;
	localparam logic [31:0] CAP_B = 32'h0010_2270;
	localparam logic [15:0] TRACK_BYTES = 16'h1960;
	localparam logic [15:0] SECT_BYTES = 16'h0200;
	localparam logic [15:0] BUF_TYPE = 16'h0003;
	localparam logic [15:0] BUF_SIZE = 16'h00C0;
	localparam logic [15:0] ECC_BYTES = 16'h0004;
	localparam logic [15:0] MAX_MULT = 16'h8008;
	localparam logic [15:0] CAPS = 16'h0F00;
	localparam logic [15:0] PIO_MODE = 16'h0200;
	localparam logic [15:0] DMA_MODE = 16'h0200;
	localparam logic [15:0] FIELDS_VALID = 16'h0003;
	localparam logic [15:0] SW_DMA = 16'h0407;
	localparam logic [15:0] MW_DMA = 16'h0203;
	localparam logic [15:0] MW_MIN_NS = 16'h0096;
	localparam logic [15:0] MW_REC_NS = 16'h0096;
	localparam logic [15:0] PIO_NOFC_NS = 16'h014D;
	localparam logic [15:0] PIO_FC_NS = 16'h00B4;
	localparam logic [15:0] DEFECT_EOL = 16'h00FF;
	localparam logic [2:0] DEFECT_SECTORS = 3'h4;
	localparam logic [7:0] LAST_WORD = 8'hFF;

	// usual path idle, fill, transfer steps one bit at a time
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FILL = 3'b001,
		ST_XFER = 3'b011,
		ST_DFILL = 3'b010,
		ST_FEAT = 3'b100
	} aif_state_t;

endpackage
`default_nettype wire

// ===== logic/aif_buf.sv
`timescale 1ns/100ps
`default_nettype none
module aif_buf (
	input wire logic pclk,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [7:0] raddr,
	output logic [15:0] rdata
);

	logic [15:0] mem [0:255];

	////////////////////////////////////////////////////////////////////////////
	// one sector of words; read data registered, no reset needed on storage
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule
`default_nettype wire

// ===== logic/aif_cmd.sv
// Operation
// [RQ1] identify: busy, build block in buffer, data request, then interrupt
// [RQ2] word 0 sets bits 11, 9, 6, 4, 3, 1 only
// [RQ3] words 1, 3, 6 give geometry; word 5 gives 512
// [RQ4] word 20 buffer type 3, word 21 size 192
// [RQ5] word 22 reports 4 ecc bytes
// [RQ6] strings low byte first; serial 10-19, firmware 23-26, model 27-46
// [RQ7] word 47 is 80h upper, 08h lower
// [RQ8] word 49 sets bits 11 to 8, upper nibble zero
// [RQ9] words 51 and 52 carry mode 2 in upper byte
// [RQ10] word 53 bit 1 set, bit 0 flags current geometry
// [RQ11] words 54-56 current geometry; 57-58 and 60-61 capacity
// [RQ12] word 59 bit 8 valid flag, low byte sectors per interrupt
// [RQ13] word 62 is 4 and 7; word 63 is 2 and 3
// [RQ14] words 65-68 cycle times 150, 150, 333, 180 ns
// [RQ15] reserved bits and words read zero
// [RQ16] set features: busy, check code, release busy, interrupt
// [RQ17] code AA enables read cache, 55 disables it
// [RQ18] code 02 enables write cache, 82 disables it
// [RQ19] unsupported feature code aborts the command
// [RQ20] cache settings return to saved values after power cycle
// [RQ21] host writes subcode, key bytes, drive select, then F0
// [RQ22] wrong key bytes reject the command as illegal
// [RQ23] defect list: busy, fetch, data request, release busy
// [RQ24] four sectors, an interrupt before each
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module aif_cmd #(
	parameter logic [7:0] CMD_IDENTIFY = 8'hEC,
	parameter logic [7:0] CMD_SET_FEATURES = 8'hEF,
	parameter logic DRIVE_ID = 1'b0,
	// arbitrary value
	parameter logic [15:0] VENDOR_WORD = 16'h0000,
	// arbitrary strings
	parameter logic [159:0] SERIAL_STR = "SN00000000000000001 ",
	parameter logic [63:0] FW_STR = "REV 0.1 ",
	parameter logic [319:0] MODEL_STR = "GENERIC ATA DISK                        "
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic intrq,
	output logic read_cache_en,
	output logic write_cache_en
);

	aif_pkg::aif_state_t state_r, state_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [2:0] sect_r, sect_nxt;
	logic [7:0] feat_r, seccnt_r, secnum_r, cyllo_r, cylhi_r, drvhd_r;
	logic geom_r, mult_valid_r, err_r, err_nxt, intrq_nxt;
	logic [7:0] mult_r;
	logic [15:0] mem_rdata;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////////////
	// string packing: first character of a pair in the low byte
	function automatic logic [15:0] str_pair(input logic [319:0] s, input int n, input int k);
		int hi;
		hi = 8 * (n - 1 - 2 * k);
		return {s[hi - 8 +: 8], s[hi +: 8]};
	endfunction

	// parameter block word by index
	function automatic logic [15:0] ident_word(input logic [7:0] w, input logic g,
		input logic mv, input logic [7:0] m);
		logic [31:0] cap;
		int i;
		cap = g ? aif_pkg::CAP_B : aif_pkg::CAP_A;
		i = int'(w);
		ident_word = 16'h0000; // [RQ15]
		if (i >= 10 && i <= 19) begin
			ident_word = str_pair(320'(SERIAL_STR), 20, i - 10); // [RQ6]
		end else if (i >= 23 && i <= 26) begin
			ident_word = str_pair(320'(FW_STR), 8, i - 23); // [RQ6]
		end else if (i >= 27 && i <= 46) begin
			ident_word = str_pair(MODEL_STR, 40, i - 27); // [RQ6]
		end else begin
			case (w)
				8'h00: ident_word = aif_pkg::ID_GENCFG; // [RQ2]
				8'h01, 8'h36: ident_word = g ? aif_pkg::CYL_B : aif_pkg::CYL_A; // [RQ3] [RQ11]
				8'h03, 8'h37: ident_word = g ? aif_pkg::HEADS_B : aif_pkg::HEADS_A; // [RQ3] [RQ11]
				8'h04: ident_word = aif_pkg::TRACK_BYTES;
				8'h05: ident_word = aif_pkg::SECT_BYTES; // [RQ3]
				8'h06, 8'h38: ident_word = g ? aif_pkg::SPT_B : aif_pkg::SPT_A; // [RQ3] [RQ11]
				8'h07, 8'h08, 8'h09: ident_word = VENDOR_WORD;
				8'h14: ident_word = aif_pkg::BUF_TYPE; // [RQ4]
				8'h15: ident_word = aif_pkg::BUF_SIZE; // [RQ4]
				8'h16: ident_word = aif_pkg::ECC_BYTES; // [RQ5]
				8'h2F: ident_word = aif_pkg::MAX_MULT; // [RQ7]
				8'h31: ident_word = aif_pkg::CAPS; // [RQ8]
				8'h33: ident_word = aif_pkg::PIO_MODE; // [RQ9]
				8'h34: ident_word = aif_pkg::DMA_MODE; // [RQ9]
				8'h35: ident_word = aif_pkg::FIELDS_VALID; // [RQ10]
				8'h39, 8'h3C: ident_word = cap[15:0]; // [RQ11]
				8'h3A, 8'h3D: ident_word = cap[31:16]; // [RQ11]
				8'h3B: ident_word = {7'h00, mv, m}; // [RQ12]
				8'h3E: ident_word = aif_pkg::SW_DMA; // [RQ13]
				8'h3F: ident_word = aif_pkg::MW_DMA; // [RQ13]
				8'h41: ident_word = aif_pkg::MW_MIN_NS; // [RQ14]
				8'h42: ident_word = aif_pkg::MW_REC_NS; // [RQ14]
				8'h43: ident_word = aif_pkg::PIO_NOFC_NS; // [RQ14]
				8'h44: ident_word = aif_pkg::PIO_FC_NS; // [RQ14]
				default: ident_word = 16'h0000; // [RQ15]
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus decode: one wait state so read data can leave a flop
	wire logic acc = psel & penable;
	wire logic done = acc & pready;
	wire logic wr_done = done & pwrite;
	wire logic rd_done = done & ~pwrite;
	wire logic sel_data = (paddr == aif_pkg::OFS_DATA);
	wire logic sel_ef = (paddr == aif_pkg::OFS_ERRFEAT);
	wire logic sel_sc = (paddr == aif_pkg::OFS_SECCNT);
	wire logic sel_sn = (paddr == aif_pkg::OFS_SECNUM);
	wire logic sel_cl = (paddr == aif_pkg::OFS_CYLLO);
	wire logic sel_ch = (paddr == aif_pkg::OFS_CYLHI);
	wire logic sel_dh = (paddr == aif_pkg::OFS_DRVHD);
	wire logic sel_sc7 = (paddr == aif_pkg::OFS_STATCMD);
	wire logic sel_cfg = (paddr == aif_pkg::OFS_CONFIG);
	wire logic hit = sel_data | sel_ef | sel_sc | sel_sn | sel_cl | sel_ch | sel_dh | sel_sc7
		| sel_cfg;

	////////////////////////////////////////////////////////////////////////////
	// status and command decode
	wire logic busy = (state_r == aif_pkg::ST_FILL) | (state_r == aif_pkg::ST_DFILL)
		| (state_r == aif_pkg::ST_FEAT);
	wire logic drq = (state_r == aif_pkg::ST_XFER);
	wire logic [7:0] status = {busy, ~busy, 2'b00, drq, 2'b00, err_r};
	wire logic [7:0] err_reg = {5'h00, err_r, 2'b00};
	wire logic cmd_go = wr_done & sel_sc7 & (state_r == aif_pkg::ST_IDLE)
		& (drvhd_r[aif_pkg::DRV_SEL] == DRIVE_ID);
	wire logic [7:0] cmd = pwdata[7:0];
	// the whole key must match, subcode included
	wire logic key_ok = (seccnt_r == aif_pkg::SUB_DEFECT) & (secnum_r == aif_pkg::KEY_1)
		& (cyllo_r == aif_pkg::KEY_2) & (cylhi_r == aif_pkg::KEY_3); // [RQ21] [RQ22]
	wire logic go_ident = cmd_go & (cmd == CMD_IDENTIFY);
	wire logic go_feat = cmd_go & (cmd == CMD_SET_FEATURES);
	wire logic go_defect = cmd_go & (cmd == aif_pkg::CMD_EXTENDED) & key_ok;
	wire logic go_abort = cmd_go & ~go_ident & ~go_feat & ~go_defect; // [RQ22]
	wire logic feat_ok = (feat_r == aif_pkg::FEAT_RC_ON) | (feat_r == aif_pkg::FEAT_RC_OFF)
		| (feat_r == aif_pkg::FEAT_WC_ON) | (feat_r == aif_pkg::FEAT_WC_OFF);
	wire logic filling = (state_r == aif_pkg::ST_FILL) | (state_r == aif_pkg::ST_DFILL);
	wire logic fill_end = filling & (idx_r == aif_pkg::LAST_WORD);
	wire logic word_pop = drq & rd_done & sel_data;
	wire logic sect_end = word_pop & (idx_r == aif_pkg::LAST_WORD);
	wire logic feat_end = (state_r == aif_pkg::ST_FEAT);
	wire logic stat_rd = rd_done & sel_sc7;
	// defect list body is not kept here: end marker then zeros
	wire logic [15:0] mem_wdata = (state_r == aif_pkg::ST_FILL)
		? ident_word(idx_r, geom_r, mult_valid_r, mult_r)
		: ((idx_r == 8'h00) ? aif_pkg::DEFECT_EOL : 16'h0000);

	////////////////////////////////////////////////////////////////////////////
	// read mux; data port reads zero outside a transfer
	assign rd_word = sel_data ? (drq ? {16'h0000, mem_rdata} : 32'h0000_0000)
		: sel_ef ? {24'h00_0000, err_reg}
		: sel_sc ? {24'h00_0000, seccnt_r}
		: sel_sn ? {24'h00_0000, secnum_r}
		: sel_cl ? {24'h00_0000, cyllo_r}
		: sel_ch ? {24'h00_0000, cylhi_r}
		: sel_dh ? {24'h00_0000, drvhd_r}
		: sel_sc7 ? {24'h00_0000, status}
		: sel_cfg ? {6'h00, write_cache_en, read_cache_en, 7'h00, mult_valid_r, mult_r,
			7'h00, geom_r}
		: 32'h0000_0000;

	aif_buf u_buf (
		.pclk(pclk),
		.we(filling),
		.waddr(idx_r),
		.wdata(mem_wdata),
		.raddr(idx_r),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// command sequencing
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		sect_nxt = sect_r;
		case (state_r)
			aif_pkg::ST_IDLE: begin
				if (go_ident) begin
					state_nxt = aif_pkg::ST_FILL; // [RQ1]
					// one sector only; a count left by an earlier command must not replay
					sect_nxt = 3'h1;
				end else if (go_feat) begin
					state_nxt = aif_pkg::ST_FEAT; // [RQ16]
				end else if (go_defect) begin
					state_nxt = aif_pkg::ST_DFILL; // [RQ23]
					sect_nxt = aif_pkg::DEFECT_SECTORS; // [RQ24]
				end
			end
			aif_pkg::ST_FILL, aif_pkg::ST_DFILL: begin
				idx_nxt = idx_r + 8'h01;
				if (fill_end) begin
					state_nxt = aif_pkg::ST_XFER; // [RQ1] [RQ23]
				end
			end
			aif_pkg::ST_XFER: begin
				if (word_pop) begin
					idx_nxt = idx_r + 8'h01;
				end
				if (sect_end) begin
					sect_nxt = sect_r - 3'h1;
					state_nxt = (sect_r > 3'h1) ? aif_pkg::ST_DFILL : aif_pkg::ST_IDLE; // [RQ24]
				end
			end
			aif_pkg::ST_FEAT: begin
				state_nxt = aif_pkg::ST_IDLE; // [RQ16]
			end
			default: begin
				state_nxt = aif_pkg::ST_IDLE;
			end
		endcase
	end

	// error flag and interrupt; a set beats a status read in the same cycle
	assign err_nxt = go_abort | (feat_end & ~feat_ok) | (err_r & ~cmd_go); // [RQ19] [RQ22]
	assign intrq_nxt = fill_end | feat_end | go_abort | (intrq & ~stat_rd); // [RQ1] [RQ16] [RQ24]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= aif_pkg::ST_IDLE;
			idx_r <= 8'h00;
			sect_r <= 3'h0;
			err_r <= 1'b0;
			intrq <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			sect_r <= sect_nxt;
			err_r <= err_nxt;
			intrq <= intrq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus handshake and answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~hit;
			prdata <= (acc & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// task file writes; the command write itself only starts work
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feat_r <= aif_pkg::TASK_RST;
			seccnt_r <= aif_pkg::TASK_RST;
			secnum_r <= aif_pkg::TASK_RST;
			cyllo_r <= aif_pkg::TASK_RST;
			cylhi_r <= aif_pkg::TASK_RST;
			drvhd_r <= aif_pkg::TASK_RST;
		end else if (wr_done) begin
			feat_r <= sel_ef ? pwdata[7:0] : feat_r;
			seccnt_r <= sel_sc ? pwdata[7:0] : seccnt_r;
			secnum_r <= sel_sn ? pwdata[7:0] : secnum_r;
			cyllo_r <= sel_cl ? pwdata[7:0] : cyllo_r;
			cylhi_r <= sel_ch ? pwdata[7:0] : cylhi_r;
			drvhd_r <= sel_dh ? pwdata[7:0] : drvhd_r;
		end
	end

	// geometry and multiple setting; cache bits only move by feature codes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			geom_r <= aif_pkg::CFG_GEOM_RST;
			mult_r <= aif_pkg::CFG_MULT_RST;
			mult_valid_r <= aif_pkg::CFG_MULT_VALID_RST;
		end else if (wr_done & sel_cfg) begin
			geom_r <= pwdata[aif_pkg::CFG_GEOM];
			mult_r <= pwdata[aif_pkg::CFG_MULT_LSB +: 8];
			mult_valid_r <= pwdata[aif_pkg::CFG_MULT_VALID];
		end
	end

	// no nonvolatile copy here: reset stands in for the power cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_cache_en <= aif_pkg::RCACHE_SAVED; // [RQ20]
			write_cache_en <= aif_pkg::WCACHE_SAVED; // [RQ20]
		end else if (feat_end) begin
			read_cache_en <= (feat_r == aif_pkg::FEAT_RC_ON) ? 1'b1
				: (feat_r == aif_pkg::FEAT_RC_OFF) ? 1'b0 : read_cache_en; // [RQ17]
			write_cache_en <= (feat_r == aif_pkg::FEAT_WC_ON) ? 1'b1
				: (feat_r == aif_pkg::FEAT_WC_OFF) ? 1'b0 : write_cache_en; // [RQ18]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks on the parameter block and command flow
	wire logic idw = (state_r == aif_pkg::ST_FILL);
	logic [8:0] busy_run_r;

	// busy run length, so a long fill needs no long repetition in a property
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_run_r <= 9'h000;
		end else begin
			busy_run_r <= busy ? busy_run_r + 9'h001 : 9'h000;
		end
	end

	ident_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		(idw && idx_r == 8'hFF) |=> (drq && intrq && !busy)) else $error("identify irq");
	fill_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		go_ident |=> (busy && !drq) [*8]) else $error("identify busy");
	gen_cfg_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
		(idw && idx_r == 8'h00) |-> mem_wdata == 16'h0A5A) else $error("word 0");
	geom_word_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		(idw && idx_r == 8'h06) |-> mem_wdata == (geom_r ? 16'h003F : 16'h0028))
		else $error("word 6");
	buf_size_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
		(idw && idx_r == 8'h15) |-> mem_wdata == 16'h00C0) else $error("word 21");
	ecc_bytes_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
		(idw && idx_r == 8'h16) |-> mem_wdata == 16'h0004) else $error("word 22");
	model_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
		(idw && idx_r == 8'h1B) |-> mem_wdata == {MODEL_STR[311:304], MODEL_STR[319:312]})
		else $error("model byte order");
	max_mult_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		(idw && idx_r == 8'h2F) |-> mem_wdata == 16'h8008) else $error("word 47");
	caps_word_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
		(idw && idx_r == 8'h31) |-> mem_wdata == 16'h0F00) else $error("word 49");
	pio_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
		(idw && idx_r == 8'h33) |-> mem_wdata == 16'h0200) else $error("word 51");
	valid_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
		(idw && idx_r == 8'h35) |-> mem_wdata == 16'h0003) else $error("word 53");
	capacity_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
		(idw && idx_r == 8'h3D) |-> mem_wdata == (geom_r ? 16'h0010 : 16'h0008))
		else $error("word 61");
	mult_word_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
		(idw && idx_r == 8'h3B) |-> mem_wdata == {7'h00, mult_valid_r, mult_r})
		else $error("word 59");
	dma_modes_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
		(idw && idx_r == 8'h3E) |-> mem_wdata == 16'h0407) else $error("word 62");
	pio_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
		(idw && idx_r == 8'h43) |-> mem_wdata == 16'h014D) else $error("word 67");
	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
		(idw && (idx_r == 8'h02 || idx_r > 8'h44)) |-> mem_wdata == 16'h0000)
		else $error("reserved word");
	feat_done_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
		go_feat |=> busy ##1 (!busy && intrq)) else $error("set features flow");
	rcache_on_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
		(feat_end && feat_r == 8'hAA) |=> read_cache_en) else $error("read cache on");
	wcache_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ18]
		(feat_end && feat_r == 8'h82) |=> !write_cache_en) else $error("write cache off");
	feat_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
		(feat_end && !feat_ok) |=> (err_r && $stable(read_cache_en) && $stable(write_cache_en)))
		else $error("feature abort");
	cache_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ20]
		!$past(presetn) |-> (read_cache_en && write_cache_en)) else $error("cache reset");
	key_reject_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ22]
		(cmd_go && cmd == 8'hF0 && !key_ok) |=> (err_r && intrq && state_r == aif_pkg::ST_IDLE))
		else $error("bad key taken");
	defect_seq_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
		go_defect |=> busy ##255 (busy && busy_run_r == 9'h0FF) ##1 (drq && !busy && intrq))
		else $error("defect flow");
	last_sector_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ24]
		(sect_end && sect_r == 3'h1) |=> (state_r == aif_pkg::ST_IDLE && !drq && !intrq))
		else $error("sector count");
	next_sector_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ24]
		(sect_end && sect_r > 3'h1) |=> (state_r == aif_pkg::ST_DFILL && busy && !drq))
		else $error("next sector");

endmodule
`default_nettype wire

// ===== verif/aif_host.sv
`timescale 1ns/100ps
`default_nettype none
// host adapter: every request stays put until pready is sampled high
module aif_host (
	input wire logic pclk,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h00,
	output logic [31:0] pwdata = 32'h0,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic err = 1'b0;
	// setup, access, hold; no wait count assumed, the bench timeout cuts a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, intrq, read_cache_en, write_cache_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	always #5 pclk = ~pclk;
	aif_cmd u_aif_cmd (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .intrq, .read_cache_en, .write_cache_en);
	aif_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	// ceiling far above the longest run, so only a hang reaches it
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, r);
	endtask
	// interrupt must come within the busy span plus margin
	task automatic wait_irq();
		int n;
		n = 0;
		while (intrq !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		check({31'h0, intrq}, 32'h1);
	endtask
	// expected block; g picks the large geometry, multiple count 10h valid
	function automatic logic [15:0] id_word(input int i, input logic g);
		case (i)
			0: return 16'h0A5A;
			1, 54: return g ? 16'h0419 : 16'h03B0;
			3, 55: return g ? 16'h0010 : 16'h000E;
			4: return 16'h1960;
			5: return 16'h0200;
			6, 56: return g ? 16'h003F : 16'h0028;
			10: return 16'h4E53;
			20: return 16'h0003;
			21: return 16'h00C0;
			22: return 16'h0004;
			47: return 16'h8008;
			49: return 16'h0F00;
			51, 52: return 16'h0200;
			53: return 16'h0003;
			57, 60: return g ? 16'h2270 : 16'h1100;
			58, 61: return g ? 16'h0010 : 16'h0008;
			59: return 16'h0110;
			62: return 16'h0407;
			63: return 16'h0203;
			65, 66: return 16'h0096;
			67: return 16'h014D;
			68: return 16'h00B4;
			default: return 16'h0000;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		check({30'h0, read_cache_en, write_cache_en}, 32'h3);
		rd(8'h20);
		check(r, 32'h0300_0800);
		rd(8'h24);
		check({r[30:0], u_host.err}, 32'h1);
	endtask
	// run twice in a row, so a second identify must not inherit a sector count
	task automatic t_identify(input logic g);
		wr(8'h20, {31'h0000_8800, g});
		wr(8'h18, 32'h0);
		wr(8'h1C, 32'hEC);
		rd(8'h1C);
		check(r, 32'h80);
		wait_irq();
		rd(8'h1C);
		check(r, 32'h48);
		// string words other than serial word 10, and vendor words 7-9, are arbitrary, so skipped
		for (int i = 0; i < 256; i++) begin
			rd(8'h00);
			if (i < 7 || i == 10) check(r, {16'h0, id_word(i, g)});
			if (i > 19 && i < 23) check(r, {16'h0, id_word(i, g)});
			if (i > 46 && i < 54) check(r, {16'h0, id_word(i, g)});
			if (i > 53 && i < 64) check(r, {16'h0, id_word(i, g)});
			if (i > 63 && i < 69) check(r, {16'h0, id_word(i, g)});
			if (i > 68) check(r, {16'h0, id_word(i, g)});
		end
		rd(8'h1C);
		check(r, 32'h40);
	endtask
	task automatic t_features();
		logic [7:0] codes [5] = '{8'h82, 8'h02, 8'hAA, 8'h55, 8'h33};
		logic [1:0] caches [5] = '{2'b10, 2'b11, 2'b11, 2'b01, 2'b01};
		for (int i = 0; i < 5; i++) begin
			wr(8'h04, {24'h0, codes[i]});
			wr(8'h1C, 32'hEF);
			wait_irq();
			rd(8'h1C);
			check(r, (i == 4) ? 32'h41 : 32'h40);
			check({30'h0, read_cache_en, write_cache_en}, {30'h0, caches[i]});
		end
		rd(8'h04);
		check(r, 32'h4);
	endtask
	// wrong last key byte first, then the exact key
	task automatic t_defect();
		wr(8'h08, 32'h04);
		wr(8'h0C, 32'hFF);
		wr(8'h10, 32'hFF);
		wr(8'h14, 32'h3E);
		wr(8'h1C, 32'hF0);
		wait_irq();
		rd(8'h1C);
		check(r, 32'h41);
		wr(8'h14, 32'h3F);
		wr(8'h1C, 32'hF0);
		rd(8'h1C);
		check(r, 32'h80);
		for (int s = 0; s < 4; s++) begin
			wait_irq();
			rd(8'h1C);
			check(r, 32'h48);
			for (int i = 0; i < 256; i++) begin
				rd(8'h00);
				check(r, (i == 0) ? 32'hFF : 32'h0);
			end
		end
		rd(8'h1C);
		check(r, 32'h40);
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// second reset in mid-run stands for a power cycle
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals();
		t_identify(1'b1);
		t_identify(1'b0);
		t_features();
		t_defect();
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals();
		report_and_stop();
	end
endmodule
`default_nettype wire
